/* test/adu_alert_unit_properties.sv */
// Purpose: port-level properties of the alert unit
// Assumes: hready is looped back from hreadyout
// Notes:   register state is unseen, so causes are bus or engine events
`timescale 1ns/100ps
`default_nettype none
module adu_alert_unit_properties (
  input wire logic                 hclk,
  input wire logic                 hresetn,
  input wire logic                 hsel,
  input wire logic [1:0]           htrans,
  input wire logic                 hwrite,
  input wire logic                 hready,
  input wire logic                 hreadyout,
  input wire logic                 hresp,
  input wire adu_pkg::adu_result_t result_i,
  input wire logic                 alert_out,
  input wire logic                 alert_oe,
  input wire logic                 conv_run,
  input wire logic                 conv_cont,
  input wire logic                 conv_restart
);
  // taken transfers and engine pulses
  wire logic tk = hsel & hready & htrans[1];
  wire logic wr = tk & hwrite;
  wire logic ev = result_i.sample_valid | result_i.final_valid;
  // one domain, so clock and reset are given once
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_okay; hreadyout && !hresp; endproperty
  a_okay: assert property (p_okay) else $error("slave not ready or not okay");
  property p_drain; alert_out == 1'b0; endproperty
  a_drain: assert property (p_drain) else $error("pin driven high");
  property p_rst; $rose(hresetn) |-> !alert_oe && conv_run && conv_cont; endproperty
  a_rst: assert property (p_rst) else $error("bad state after reset");
  property p_cause;
    $changed(alert_oe) |-> $past(ev) || $past(ev, 2) || $past(tk) || $past(tk, 2);
  endproperty
  a_cause: assert property (p_cause) else $error("pin moved without cause");
  property p_restart; conv_restart |-> $past(wr, 2) || $past(wr, 3); endproperty
  a_restart: assert property (p_restart) else $error("restart without write");
  property p_trig; conv_run && !conv_cont && result_i.final_valid |-> ##[1:2] !conv_run;
  endproperty
  a_trig: assert property (p_trig) else $error("one-shot did not stop");
  property p_wake; $rose(conv_run) |-> $past(wr, 2) || $past(wr, 3); endproperty
  a_wake: assert property (p_wake) else $error("left shutdown alone");
  property p_mode; $changed(conv_cont) |-> $past(wr, 2) || $past(wr, 3); endproperty
  a_mode: assert property (p_mode) else $error("mode moved without write");
endmodule
bind adu_alert_unit adu_alert_unit_properties u_props (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .result_i(result_i), .alert_out(alert_out), .alert_oe(alert_oe),
  .conv_run(conv_run), .conv_cont(conv_cont), .conv_restart(conv_restart));
`default_nettype wire

/* test/adu_engine_model.sv */
// Purpose: conversion engine beside the alert unit, plus the pulled-up pin
// Assumes: the bench asks for one conversion with go
// Notes:   a stopped engine sends nothing, as the real one would
`timescale 1ns/100ps
`default_nettype none
module adu_engine_model (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  conv_run,
  input  wire logic                  go,
  input  wire logic                  fin,
  input  wire logic [63:0]           vals,
  input  wire logic                  alert_oe,
  output var  adu_pkg::adu_result_t  res,
  output wire logic                  pin
);
  // data toggles between pulses so stale values never look valid
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      res <= '0;
    end else begin
      res.sample_valid <= go & conv_run;
      res.final_valid <= go & fin & conv_run;
      res[63:0] <= go ? vals : ~res[63:0];
    end
  end
  // board pull-up decides the level of the released pin
  assign pin = alert_oe ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

/* test/tb_alert_diagnostic_unit.sv */
// Purpose: self-checking bench of the alert unit
// Assumes: zero-wait slave, engine model supplies results
// Notes:   expected flags come from the bench's own compare
`timescale 1ns/100ps
`default_nettype none
module tb_alert_diagnostic_unit;
  logic                 hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic                 oe, ao, run, cont, rs, go, fin, pin;
  logic [7:0]           haddr;
  logic [1:0]           htrans;
  logic [31:0]          hwdata, hrdata, q;
  logic [63:0]          vals, v;
  logic [15:0]          lim [6];
  adu_pkg::adu_result_t res;
  adu_pkg::adu_health_t hl;
  int                   bad_count, tests_run, rcnt, r;

  adu_alert_unit DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .result_i(res), .health_i(hl),
    .alert_in(pin), .alert_out(ao), .alert_oe(oe), .conv_run(run), .conv_cont(cont),
    .conv_restart(rs));
  adu_engine_model u_eng (.hclk(hclk), .hresetn(hresetn), .conv_run(run), .go(go),
    .fin(fin), .vals(vals), .alert_oe(oe), .res(res), .pin(pin));

  // 200 MHz clock and restart pulse counter
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  always @(posedge hclk) if (rs === 1'b1) rcnt++;

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  // one single transfer; hang bound ends the run
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 64);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 64);
    q = hrdata;
    if (n >= 64) begin
      bad_count++;
      $display("[ERR] %0t bus hang", $time);
      print_verdict();
    end
  endtask
  // idle cycles let the write and its side effects land
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    repeat (2) @(posedge hclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic fire(input logic [63:0] x, input logic f);
    go <= 1'b1;
    fin <= f;
    vals <= x;
    @(posedge hclk);
    go <= 1'b0;
    repeat (2) @(posedge hclk);
  endtask
  // shunt signed, the rest unsigned
  function automatic logic [31:0] flags(input logic [63:0] x);
    logic [15:0] s, a, h, w;
    {s, a, h, w} = x;
    flags = 32'h0;
    flags[7] = h > lim[4];
    flags[6] = $signed(s) > $signed(lim[1]);
    flags[5] = $signed(s) < $signed(lim[0]);
    flags[4] = a > lim[2];
    flags[3] = a < lim[3];
    flags[2] = w > lim[5];
  endfunction
  task automatic cmp(input logic [63:0] x);
    fire(x, 1'b1);
    chk(pin, |flags(x) ? 32'h0 : 32'h1);
    rd(adu_pkg::OFS_DIAG, flags(x) | 32'h3);
  endtask
  task automatic defs;
    lim = '{adu_pkg::RST_SLOW, adu_pkg::RST_SUPP, adu_pkg::RST_BUPP,
      adu_pkg::RST_BLOW, adu_pkg::RST_HEAT, adu_pkg::RST_PWR};
    for (int i = 0; i < 6; i++) rd(8'h0C + 8'(4 * i), {16'h0, lim[i]});
  endtask

  // main sequence
  initial begin
    hresetn = 1'b0; hsel = 1'b0; hwrite = 1'b0; htrans = 2'h0; haddr = 8'h00;
    hwdata = 32'h0; go = 1'b0; fin = 1'b0; vals = 64'h0; hl = 4'h1;
    bad_count = 0; tests_run = 0; rcnt = 0;
    q = $urandom(72929);
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    defs();
    rd(adu_pkg::OFS_DIAG, 32'h1);
    rd(8'h24, 32'h0);
    chk(pin, 32'h1);
    $display("reset test done");
    for (int i = 0; i < 6; i++) begin
      lim[i] = i < 2 ? 16'($urandom) : 16'($urandom) & 16'h7FFF;
      wr(8'h0C + 8'(4 * i), {16'($urandom), lim[i]});
      rd(8'h0C + 8'(4 * i), {16'h0, lim[i]});
    end
    repeat (12) begin
      v = {$urandom, $urandom} & 64'hFFFF_7FFF_7FFF_7FFF;
      cmp(v);
    end
    wr(adu_pkg::OFS_CFG, 32'h8000);
    defs();
    cmp(64'h8000_0000_0000_0000);
    cmp(64'h7FFF_0000_0000_0000);
    cmp(64'h8001_FFFF_FFFF_8000);
    $display("compare test done");
    lim[2] = 16'h1000;
    wr(adu_pkg::OFS_BUPP, 32'h1000);
    fire(64'h0, 1'b1); // flags of the last compare would stick once held
    wr(adu_pkg::OFS_DIAG, 32'h8000);
    fire(64'h0000_1001_0000_0000, 1'b1);
    fire(64'h0, 1'b1);
    chk(pin, 32'h0);
    rd(adu_pkg::OFS_DIAG, 32'h8013);
    chk(pin, 32'h1);
    wr(adu_pkg::OFS_DIAG, 32'h4000);
    fire(64'h0, 1'b1);
    chk(pin, 32'h0);
    @(posedge hclk);
    chk(pin, 32'h1);
    fire(64'h0000_1001_0000_0000, 1'b1);
    @(posedge hclk);
    chk(pin, 32'h0);
    fire(64'h0, 1'b1);
    $display("hold and done test done");
    wr(adu_pkg::OFS_DIAG, 32'h2000);
    rd(adu_pkg::OFS_DIAG, 32'h2003);
    fire(64'h0000_1001_0000_0000, 1'b0);
    rd(adu_pkg::OFS_DIAG, 32'h2001);
    fire(64'h0000_1001_0000_0000, 1'b1);
    rd(adu_pkg::OFS_DIAG, 32'h2013);
    wr(adu_pkg::OFS_DIAG, 32'h1000);
    fire(64'h0, 1'b1);
    chk(pin, 32'h0);
    fire(64'h0000_1001_0000_0000, 1'b1);
    chk(pin, 32'h1);
    fire(64'h0, 1'b1);
    wr(adu_pkg::OFS_DIAG, 32'h0);
    rd(adu_pkg::OFS_DIAG, 32'h3);
    for (int i = 0; i < 3; i++) begin
      hl <= {3'(4 >> i), 1'b1};
      @(posedge hclk);
      hl <= 4'h1;
      repeat (2) @(posedge hclk);
      chk(pin, 32'h1);
      rd(adu_pkg::OFS_DIAG, 32'h1 | (32'h100 << (i == 0 ? 0 : 3 - i)));
    end
    $display("pin option test done");
    fire(64'h0, 1'b1);
    wr(adu_pkg::OFS_ADC, {30'h0, adu_pkg::MODE_CONT});
    rd(adu_pkg::OFS_DIAG, 32'h1);
    fire(64'h0, 1'b1);
    wr(adu_pkg::OFS_ADC, {30'h0, adu_pkg::MODE_SHUT});
    rd(adu_pkg::OFS_DIAG, 32'h3);
    chk(run, 32'h0);
    wr(adu_pkg::OFS_BUPP, 32'h2000);
    rd(adu_pkg::OFS_BUPP, 32'h2000);
    r = rcnt;
    wr(adu_pkg::OFS_ADC, {30'h0, adu_pkg::MODE_TRIG});
    chk(run, 32'h1);
    fire(64'h0, 1'b1);
    @(posedge hclk);
    chk(run, 32'h0);
    chk(rcnt - r, 32'h1);
    rd(adu_pkg::OFS_DIAG, 32'h3);
    fire(64'h0000_3000_0000_0000, 1'b1);
    chk(run, 32'h0);
    rd(adu_pkg::OFS_DIAG, 32'h1);
    wr(adu_pkg::OFS_ADC, {30'h0, adu_pkg::MODE_CONT});
    chk({run, cont}, 32'h3);
    $display("mode test done");
    print_verdict();
  end
endmodule
`default_nettype wire

/* verilog/adu_alert_unit.sv */
// Purpose: limit compare, alert pin, diag status and conversion mode control
// Assumes: zero-wait AHB-Lite slave, engine reports synchronous to hclk
// Notes:   alert pin is open-drain: out stays low, enable carries the level
// How it works
// - every result is compared against its limit; breach can raise the pin
// - shunt_below_flag when signed shunt below signed lower limit, default 0x8000
// - shunt_above_flag when signed shunt above signed upper limit, default 0x7FFF
// - rail, heat and watts flags compare to own limits, positive values
// - diag register shows which diagnostic raised the pin
// - with fault_hold_enable the pin stays asserted after conditions vanish
// - reading the diag register releases a held pin
// - with done_signal_enable the pin asserts on a finished conversion
// - done_status_flag records every final averaged result regardless of enable
// - averaged_compare_enable compares only final averaged results
// - pin active low after reset; pin_inversion_select makes it active high
// - pin is open-drain; board pull-up defines the idle level while active low
// - arithmetic_overflow_bit set on any internal arithmetic overflow
// - trim_health_bit reads one while trim memory is healthy
// - energy_wrap_bit set when energy accumulator overflows
// - charge_wrap_bit set when charge accumulator overflows
// - overflow and health bits appear only in status, never on the pin
// - register reads and writes work in shutdown
// - shutdown lasts until a triggered or continuous command is written or a software reset
// - a triggered conversion finishes then returns to shutdown
// - reset returns every register to its default
// - writing the software reset bit acts like a supply-start reset
// - done flag clears on diag read and on non-shutdown adc writes
// - writing a triggered or continuous mode aborts and restarts the conversion; writing shutdown only stops it
`timescale 1ns/100ps
`default_nettype none
module adu_alert_unit (
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 hsel,
  input  wire logic [7:0]           haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  input  wire adu_pkg::adu_result_t result_i,
  input  wire adu_pkg::adu_health_t health_i,
  input  wire logic                 alert_in,
  output logic                      alert_out,
  output logic                      alert_oe,
  output logic                      conv_run,
  output logic                      conv_cont,
  output logic                      conv_restart
);
  // bus state
  logic        wr_pend_q, wr_pend_d;
  logic [7:0]  wr_addr_q, wr_addr_d;
  logic [31:0] rdata_q, rdata_d;
  // register state
  logic [15:0] slow_q, slow_d, supp_q, supp_d, bupp_q, bupp_d;
  logic [15:0] blow_q, blow_d, heat_q, heat_d, pwr_q, pwr_d;
  logic [1:0]  mode_q, mode_d;
  logic [3:0]  diag_ctl_q, diag_ctl_d; // hold, done_en, avg, pol
  logic [4:0]  lim_q, lim_d;           // heat, s_above, s_below, r_above, r_below
  logic        watts_q, watts_d;
  logic        done_q, done_d;
  logic        arith_q, arith_d, energy_q, energy_d, charge_q, charge_d;
  logic        held_q, held_d;
  logic        oe_q, oe_d;
  adu_pkg::adu_conv_t st_q, st_d;
  logic        restart_q, restart_d;
  logic        run_q, run_d, cont_q, cont_d;
  // decode
  logic        rd_take, wr_take, diag_rd, wr_now, swrst, adc_wr;
  logic        cmp_en;
  logic [5:0]  breach;
  logic        cond, assert_now;
  logic [15:0] wd;

  // address phase accepted only when the bus is ready
  assign rd_take = hsel & hready & htrans[1] & ~hwrite;
  assign wr_take = hsel & hready & htrans[1] & hwrite;
  assign diag_rd = rd_take & (haddr == adu_pkg::OFS_DIAG);
  assign wr_now  = wr_pend_q;
  assign wd      = hwdata[15:0];
  assign swrst   = wr_now & (wr_addr_q == adu_pkg::OFS_CFG) & wd[adu_pkg::B_SWRST];
  assign adc_wr  = wr_now & (wr_addr_q == adu_pkg::OFS_ADC);

  // compare on every sample, or only on final averaged results
  assign cmp_en = diag_ctl_q[1] ? result_i.final_valid : result_i.sample_valid;

  // limit checks; shunt signed, rail, heat and watts positive only
  always_comb begin
    breach[0] = $signed(result_i.shunt) < $signed(slow_q);
    breach[1] = $signed(result_i.shunt) > $signed(supp_q);
    breach[2] = result_i.rail > bupp_q;
    breach[3] = result_i.rail < blow_q;
    breach[4] = result_i.heat > heat_q;
    breach[5] = result_i.watts > pwr_q;
  end

  // bus pipeline and read mux; reads work in any conversion state
  always_comb begin
    wr_pend_d = wr_take;
    wr_addr_d = wr_take ? haddr : wr_addr_q;
    rdata_d   = rdata_q;
    if (rd_take) begin
      rdata_d = 32'h0000_0000;
      unique case (haddr)
        adu_pkg::OFS_CFG:  rdata_d = 32'h0000_0000;
        adu_pkg::OFS_ADC:  rdata_d = {30'h0000_0000, mode_q};
        adu_pkg::OFS_DIAG: rdata_d = {16'h0000, diag_ctl_q, 1'b0, energy_q, charge_q, arith_q,
                                      lim_q, watts_q, done_q, health_i.trim_ok};
        adu_pkg::OFS_SLOW: rdata_d = {16'h0000, slow_q};
        adu_pkg::OFS_SUPP: rdata_d = {16'h0000, supp_q};
        adu_pkg::OFS_BUPP: rdata_d = {16'h0000, bupp_q};
        adu_pkg::OFS_BLOW: rdata_d = {16'h0000, blow_q};
        adu_pkg::OFS_HEAT: rdata_d = {16'h0000, heat_q};
        adu_pkg::OFS_PWR:  rdata_d = {16'h0000, pwr_q};
        default:           rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // limit and control registers; software reset restores defaults
  always_comb begin
    slow_d     = slow_q;
    supp_d     = supp_q;
    bupp_d     = bupp_q;
    blow_d     = blow_q;
    heat_d     = heat_q;
    pwr_d      = pwr_q;
    mode_d     = mode_q;
    diag_ctl_d = diag_ctl_q;
    if (swrst) begin
      slow_d     = adu_pkg::RST_SLOW;
      supp_d     = adu_pkg::RST_SUPP;
      bupp_d     = adu_pkg::RST_BUPP;
      blow_d     = adu_pkg::RST_BLOW;
      heat_d     = adu_pkg::RST_HEAT;
      pwr_d      = adu_pkg::RST_PWR;
      mode_d     = adu_pkg::RST_MODE;
      diag_ctl_d = 4'h0;
    end else if (wr_now) begin
      unique case (wr_addr_q)
        adu_pkg::OFS_ADC:  mode_d     = wd[1:0];
        adu_pkg::OFS_DIAG: diag_ctl_d = wd[adu_pkg::B_HOLD:adu_pkg::B_POL];
        adu_pkg::OFS_SLOW: slow_d     = wd;
        adu_pkg::OFS_SUPP: supp_d     = wd;
        adu_pkg::OFS_BUPP: bupp_d     = wd;
        adu_pkg::OFS_BLOW: blow_d     = wd;
        adu_pkg::OFS_HEAT: heat_d     = wd;
        adu_pkg::OFS_PWR:  pwr_d      = wd;
        default:           mode_d     = mode_q;
      endcase
    end
  end

  // status flags; a new event wins over a read or adc-write clear, but software reset clears over any event
  always_comb begin
    lim_d    = lim_q;
    watts_d  = watts_q;
    done_d   = done_q;
    arith_d  = arith_q;
    energy_d = energy_q;
    charge_d = charge_q;
    // limit flags follow the condition, or stick until read when held
    if (diag_rd | ~diag_ctl_q[3]) begin
      lim_d   = diag_ctl_q[3] ? 5'h00 : lim_q;
      watts_d = diag_ctl_q[3] ? 1'b0 : watts_q;
    end
    if (cmp_en) begin
      if (diag_ctl_q[3]) begin
        lim_d   = lim_d | {breach[4], breach[1], breach[0], breach[2], breach[3]};
        watts_d = watts_d | breach[5];
      end else begin
        lim_d   = {breach[4], breach[1], breach[0], breach[2], breach[3]};
        watts_d = breach[5];
      end
    end
    // done flag clears on diag read or an adc write that is not shutdown
    if (diag_rd | (adc_wr & (wd[1:0] != adu_pkg::MODE_SHUT))) begin
      done_d = 1'b0;
    end
    if (result_i.final_valid) begin
      done_d = 1'b1;
    end
    if (diag_rd) begin
      arith_d  = 1'b0;
      energy_d = 1'b0;
      charge_d = 1'b0;
    end
    if (health_i.arith_ovf) begin
      arith_d = 1'b1;
    end
    if (health_i.energy_ovf) begin
      energy_d = 1'b1;
    end
    if (health_i.charge_ovf) begin
      charge_d = 1'b1;
    end
    if (swrst) begin
      lim_d    = 5'h00;
      watts_d  = 1'b0;
      done_d   = 1'b0;
      arith_d  = 1'b0;
      energy_d = 1'b0;
      charge_d = 1'b0;
    end
  end

  // pin source: limit flags plus done reporting, never the overflow bits
  assign cond = (|lim_d) | watts_d | (diag_ctl_q[2] & result_i.final_valid);

  // alert hold and open-drain level
  always_comb begin
    held_d = held_q;
    if (diag_rd) begin
      held_d = 1'b0;
    end
    if (diag_ctl_q[3] & cond) begin
      held_d = 1'b1;
    end
    if (swrst | ~diag_ctl_q[3]) begin
      held_d = 1'b0;
    end
    assert_now = diag_ctl_q[3] ? held_d : cond;
    // active low drives while asserted; active high drives while idle
    oe_d = assert_now ^ (diag_ctl_d[0] & ~swrst);
  end

  // conversion mode control
  always_comb begin
    st_d      = st_q;
    restart_d = 1'b0;
    if (swrst) begin
      st_d      = adu_pkg::ST_CONT;
      restart_d = 1'b1;
    end else if (adc_wr) begin
      unique case (wd[1:0])
        adu_pkg::MODE_TRIG: st_d = adu_pkg::ST_TRIG;
        adu_pkg::MODE_CONT: st_d = adu_pkg::ST_CONT;
        default:            st_d = adu_pkg::ST_SHUT;
      endcase
      restart_d = (wd[1:0] != adu_pkg::MODE_SHUT);
    end else if ((st_q == adu_pkg::ST_TRIG) & result_i.final_valid) begin
      st_d = adu_pkg::ST_SHUT;
    end
    // decoded from the next state so both engine pins leave flops
    run_d  = (st_d != adu_pkg::ST_SHUT);
    cont_d = (st_d == adu_pkg::ST_CONT);
  end

  // bus pipeline registers; no transfer is pending after reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rdata_q   <= 32'h0000_0000;
    end else begin
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      rdata_q   <= rdata_d;
    end
  end

  // limit and control registers; power-up values match the software reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slow_q     <= adu_pkg::RST_SLOW;
      supp_q     <= adu_pkg::RST_SUPP;
      bupp_q     <= adu_pkg::RST_BUPP;
      blow_q     <= adu_pkg::RST_BLOW;
      heat_q     <= adu_pkg::RST_HEAT;
      pwr_q      <= adu_pkg::RST_PWR;
      mode_q     <= adu_pkg::RST_MODE;
      diag_ctl_q <= 4'h0;
    end else begin
      slow_q     <= slow_d;
      supp_q     <= supp_d;
      bupp_q     <= bupp_d;
      blow_q     <= blow_d;
      heat_q     <= heat_d;
      pwr_q      <= pwr_d;
      mode_q     <= mode_d;
      diag_ctl_q <= diag_ctl_d;
    end
  end

  // status flags; trim health is not stored, it is read live
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lim_q    <= 5'h00;
      watts_q  <= 1'b0;
      done_q   <= 1'b0;
      arith_q  <= 1'b0;
      energy_q <= 1'b0;
      charge_q <= 1'b0;
    end else begin
      lim_q    <= lim_d;
      watts_q  <= watts_d;
      done_q   <= done_d;
      arith_q  <= arith_d;
      energy_q <= energy_d;
      charge_q <= charge_d;
    end
  end

  // alert hold and pin enable; the pin is released while in reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      held_q <= 1'b0;
      oe_q   <= 1'b0;
    end else begin
      held_q <= held_d;
      oe_q   <= oe_d;
    end
  end

  // conversion state; the engine starts in continuous mode after reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q      <= adu_pkg::ST_CONT;
      restart_q <= 1'b0;
      run_q     <= 1'b1;
      cont_q    <= 1'b1;
    end else begin
      st_q      <= st_d;
      restart_q <= restart_d;
      run_q     <= run_d;
      cont_q    <= cont_d;
    end
  end

  // outputs straight from flops or tied constants; zero wait, always OKAY
  assign hrdata       = rdata_q;
  assign hreadyout    = 1'b1;
  assign hresp        = 1'b0;
  assign alert_out    = 1'b0;
  assign alert_oe     = oe_q;
  assign conv_run     = run_q;
  assign conv_cont    = cont_q;
  assign conv_restart = restart_q;
  // pin level read back is unused: the unit knows what it drives
  logic unused_ok;
  assign unused_ok = alert_in ^ (|hsize) ^ (|hwdata[31:16]) ^ htrans[0];
endmodule
`default_nettype wire

/* verilog/adu_pkg.sv */
// Purpose: shared constants and types of the alert diagnostic unit
// Assumes: 32-bit AHB-Lite register bus, 16-bit registers in low bits
// Notes:   offsets are byte addresses, one aligned word each
`default_nettype none
package adu_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CFG   = 8'h00;
  localparam logic [7:0] OFS_ADC   = 8'h04;
  localparam logic [7:0] OFS_DIAG  = 8'h08;
  localparam logic [7:0] OFS_SLOW  = 8'h0C;
  localparam logic [7:0] OFS_SUPP  = 8'h10;
  localparam logic [7:0] OFS_BUPP  = 8'h14;
  localparam logic [7:0] OFS_BLOW  = 8'h18;
  localparam logic [7:0] OFS_HEAT  = 8'h1C;
  localparam logic [7:0] OFS_PWR   = 8'h20;
  // reset values of the limit registers
  localparam logic [15:0] RST_SLOW = 16'h8000;
  localparam logic [15:0] RST_SUPP = 16'h7FFF;
  localparam logic [15:0] RST_BUPP = 16'h7FFF;
  localparam logic [15:0] RST_BLOW = 16'h0000;
  localparam logic [15:0] RST_HEAT = 16'hFFFF;
  localparam logic [15:0] RST_PWR  = 16'h7FFF;
  // field positions
  localparam int B_SWRST   = 15; // config: software reset request
  localparam int B_HOLD    = 15; // diag: fault_hold_enable
  localparam int B_DONEEN  = 14; // diag: done_signal_enable
  localparam int B_AVG     = 13; // diag: averaged_compare_enable
  localparam int B_POL     = 12; // diag: pin_inversion_select
  localparam int B_ENERGY  = 10;
  localparam int B_CHARGE  = 9;
  localparam int B_ARITH   = 8;
  localparam int B_HEAT    = 7;
  localparam int B_SABOVE  = 6;
  localparam int B_SBELOW  = 5;
  localparam int B_RABOVE  = 4;
  localparam int B_RBELOW  = 3;
  localparam int B_WATTS   = 2;
  localparam int B_DONE    = 1;
  localparam int B_TRIM    = 0;
  // conversion mode field codes, bits [1:0] of the adc register
  localparam logic [1:0] MODE_SHUT = 2'h0;
  localparam logic [1:0] MODE_TRIG = 2'h1;
  localparam logic [1:0] MODE_CONT = 2'h2;
  localparam logic [1:0] RST_MODE  = 2'h2;

  typedef enum logic [1:0] {ST_SHUT, ST_TRIG, ST_CONT} adu_conv_t;

  // results handed over by the conversion engine
  typedef struct packed {
    logic        sample_valid; // one conversion finished
    logic        final_valid;  // averaging finished, results final
    logic [15:0] shunt;
    logic [15:0] rail;
    logic [15:0] heat;
    logic [15:0] watts;
  } adu_result_t;

  // overflow and health reports from the arithmetic engine
  typedef struct packed {
    logic arith_ovf;
    logic energy_ovf;
    logic charge_ovf;
    logic trim_ok;
  } adu_health_t;
endpackage
`default_nettype wire
